//--- core/adpcm_cfg_map.svh
// Bit positions, reset values and timing constants of the channel configuration port
`ifndef ADPCM_CFG_MAP_SVH
`define ADPCM_CFG_MAP_SVH

// ****************************************
// Side indices
// ****************************************
`define SIDE_Y_IDX 0
`define SIDE_X_IDX 1

// ****************************************
// Device select command byte
// ****************************************
`define SEL_SIDE_BIT 6
`define SEL_ADDR_MSB 5

// ****************************************
// Channel control byte
// ****************************************
`define CTRL_IDLE_BIT 5
`define CTRL_COEF_BIT 4
`define CTRL_PASS_BIT 3
`define CTRL_LAW_BIT 2
`define CTRL_DIR_BIT 0

// ****************************************
// Slot number byte
// ****************************************
`define SLOT_MSB 5
`define SLOT_ZERO 6'h00

// ****************************************
// Reset values
// ****************************************
`define IDLE_RST 1'b1
`define FIELD_RST 1'b0

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS 10
`define WAKE_TIME_MS 200
`define COEF_RST_CYCLES 32
`define NIBBLE_LAST_BIT 3'h3
`define BYTE_LAST_BIT 3'h7

`endif

//--- core/adpcm_cfg_pkg.sv
// Types shared by the channel configuration port
package adpcm_cfg_pkg;

  // Effective settings of one PCM side
  typedef struct packed {
    logic idle_power_down;
    logic coefficient_reset;
    logic passthrough_enable;
    logic mu_law;
    logic coding_direction;
    logic [5:0] input_slot_number;
    logic [5:0] output_slot_number;
  } side_cfg_s;

  // Serial write sequencer
  typedef enum logic [2:0] {
    ST_WAIT,
    ST_ADDR,
    ST_CTRL,
    ST_ITS,
    ST_OTS,
    ST_DONE,
    ST_IGNORE
  } ser_state_e;

endpackage

//--- core/adpcm_channel_config_port.sv
// Configuration front end of the dual-side speech compression processor
//
// Summary of operation
// - Reset restarts both algorithms, zeroes settings, but sets idle on both sides.
// - Strap low disables serial port, clears registers, settings come from pins.
// - Strap mode fixes input and output slots of both sides at zero.
// - Strap mode coding from address pins 0 and 3, law from 2 and 5.
// - Strap mode idle: serial data pin for Y, chip select pin for X.
// - Both sides idle puts the device in low-power standby.
// - Revised variant resumes within 200 ms after a side leaves idle.
// - Older variant needs a reset after leaving idle, then resumes at once; here reset idles both sides, so the engine never runs.
// - First byte compared with six address straps; mismatch ignores the write.
// - After a match, next bytes are control, input slot, output slot.
// - Select byte bit 6 picks the side: zero Y, one X.
// - Control bit 5 idles the side and tri-states its output.
// - Control bit 4 restarts coefficients; device clears it when finished.
// - Control bit 3 with idle clear passes data uncoded between slots.
// - Control bit 2 selects A-law (zero) or mu-law (one) per side.
// - Control bit 0 picks expand or compress; bits 7, 6, 1 written zero.
// - Slot counters start at frame sync; slots 4 bits expanding, 8 compressing.
// - Chip select frames a write; data sampled on serial clock rise, LSB first.
// - PCM outputs are tri-stated while a register update is in progress.
// - Slot bytes carry a six-bit slot number; upper two bits written zero.
`timescale 1ns/1ps
`include "adpcm_cfg_map.svh"
module adpcm_channel_config_port #(
  parameter bit REVISED_ALGO = 1'b1,
  parameter int WAKE_CYCLES = `WAKE_TIME_MS * 1000000 / `CLK_PERIOD_NS,
  parameter int COEF_RST_CYCLES = `COEF_RST_CYCLES
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  // Straps
  input wire logic port_mode_strap_in,
  input wire logic [5:0] device_address_straps_in,
  // Serial configuration port
  input wire logic serial_clock_in,
  input wire logic config_serial_input_in,
  input wire logic chip_select_n_in,
  // PCM timing
  input wire logic side_x_data_clock_in,
  input wire logic side_x_frame_sync_in,
  input wire logic side_y_data_clock_in,
  input wire logic side_y_frame_sync_in,
  // Effective settings
  output adpcm_cfg_pkg::side_cfg_s side_x_cfg_out,
  output adpcm_cfg_pkg::side_cfg_s side_y_cfg_out,
  // Engine state
  output logic standby_out,
  output logic engine_run_out,
  output logic update_busy_out,
  // Slot windows and output drive
  output logic side_x_in_slot_out,
  output logic side_y_in_slot_out,
  output logic side_x_drive_en_out,
  output logic side_y_drive_en_out
);

  import adpcm_cfg_pkg::*;

  localparam int COEF_MAX = COEF_RST_CYCLES + 2;
  localparam int NPINS = 14;

  // ****************************************
  // Parameter checks
  // ****************************************
  if (WAKE_CYCLES < 1 || COEF_RST_CYCLES < 1 || COEF_RST_CYCLES > 255) begin : g_bad_param
    $error("wake or coefficient reset count out of range");
  end

  // ****************************************
  // Pin synchronisation
  // ****************************************
  logic [NPINS-1:0] pins_raw;
  logic [NPINS-1:0] pins_s;
  logic sw_mode_s;
  logic [5:0] addr_s;
  logic sclk_s;
  logic sdi_s;
  logic cs_n_s;
  logic [1:0] dclk_s;
  logic [1:0] fs_s;

  assign pins_raw = {port_mode_strap_in, device_address_straps_in, serial_clock_in, config_serial_input_in,
                     chip_select_n_in, side_x_data_clock_in, side_x_frame_sync_in, side_y_data_clock_in,
                     side_y_frame_sync_in};

  pin_sync #(.WIDTH(NPINS)) u_pin_sync (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .pins_in(pins_raw),
    .pins_out(pins_s)
  );

  assign sw_mode_s = pins_s[13];
  assign addr_s = pins_s[12:7];
  assign sclk_s = pins_s[6];
  assign sdi_s = pins_s[5];
  assign cs_n_s = pins_s[4];
  assign dclk_s = {pins_s[3], pins_s[1]};
  assign fs_s = {pins_s[2], pins_s[0]};

  // Synchroniser shows reset zeros for two edges; strap decoding waits for real pin levels
  logic [1:0] sync_warm_r;
  logic strap_act;
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync_warm_r <= 2'b00;
    end else begin
      sync_warm_r <= {sync_warm_r[0], 1'b1};
    end
  end
  assign strap_act = !sw_mode_s && sync_warm_r[1];

  // ****************************************
  // Serial receiver
  // ****************************************
  ser_state_e state_r;
  ser_state_e state_nxt;
  logic sclk_d_r;
  logic cs_n_d_r;
  logic [7:0] shift_r;
  logic [7:0] shift_nxt;
  logic [2:0] bit_cnt_r;
  logic side_sel_r;
  logic sclk_rise;
  logic cs_fall;
  logic byte_done;

  function automatic logic addr_match(input logic [7:0] b, input logic [5:0] a);
    return b[`SEL_ADDR_MSB:0] == a;
  endfunction

  function automatic side_cfg_s ctrl_apply(input side_cfg_s cur, input logic [7:0] b);
    side_cfg_s c;
    c = cur;
    c.idle_power_down = b[`CTRL_IDLE_BIT];
    c.coefficient_reset = b[`CTRL_COEF_BIT];
    c.passthrough_enable = b[`CTRL_PASS_BIT];
    c.mu_law = b[`CTRL_LAW_BIT];
    c.coding_direction = b[`CTRL_DIR_BIT];
    return c;
  endfunction

  assign sclk_rise = sclk_s & ~sclk_d_r;
  assign cs_fall = ~cs_n_s & cs_n_d_r;
  assign shift_nxt = {sdi_s, shift_r[7:1]};
  assign byte_done = sclk_rise && (bit_cnt_r == 3'h7) && (state_r != ST_WAIT);

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sclk_d_r <= 1'b0;
      cs_n_d_r <= 1'b1;
    end else begin
      sclk_d_r <= sclk_s;
      cs_n_d_r <= cs_n_s;
    end
  end

  always_comb begin
    state_nxt = state_r;
    if (!sw_mode_s || cs_n_s) begin
      state_nxt = ST_WAIT;
    end else begin
      unique case (state_r)
        ST_WAIT: if (cs_fall) state_nxt = ST_ADDR;
        ST_ADDR: if (byte_done) state_nxt = addr_match(shift_nxt, addr_s) ? ST_CTRL : ST_IGNORE;
        ST_CTRL: if (byte_done) state_nxt = ST_ITS;
        ST_ITS: if (byte_done) state_nxt = ST_OTS;
        ST_OTS: if (byte_done) state_nxt = ST_DONE;
        ST_DONE, ST_IGNORE: state_nxt = state_r;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_r <= ST_WAIT;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      shift_r <= 8'h00;
      bit_cnt_r <= 3'h0;
    end else if (state_r == ST_WAIT) begin
      bit_cnt_r <= 3'h0;
    end else if (sclk_rise) begin
      shift_r <= shift_nxt;
      bit_cnt_r <= bit_cnt_r + 3'h1;
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      side_sel_r <= 1'b0;
    end else if (state_r == ST_ADDR && state_nxt == ST_CTRL) begin
      side_sel_r <= shift_nxt[`SEL_SIDE_BIT];
    end
  end

  // ****************************************
  // Software registers and coefficient reset
  // ****************************************
  side_cfg_s sw_cfg_r [2];
  side_cfg_s eff_cfg_r [2];
  logic [7:0] coef_cnt_r [2];
  logic [1:0] coef_done;

  for (genvar s = 0; s < 2; s++) begin : g_coef
    assign coef_done[s] = sw_cfg_r[s].coefficient_reset && (coef_cnt_r[s] == 8'(COEF_RST_CYCLES - 1));
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
        coef_cnt_r[s] <= 8'h00;
      end else if (!sw_cfg_r[s].coefficient_reset || coef_done[s]) begin
        coef_cnt_r[s] <= 8'h00;
      end else begin
        coef_cnt_r[s] <= coef_cnt_r[s] + 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (int s = 0; s < 2; s++) begin
        sw_cfg_r[s] <= '{`IDLE_RST, `FIELD_RST, `FIELD_RST, `FIELD_RST, `FIELD_RST, `SLOT_ZERO, `SLOT_ZERO};
      end
    end else if (strap_act) begin
      for (int s = 0; s < 2; s++) begin
        sw_cfg_r[s] <= '0;
      end
    end else begin
      for (int s = 0; s < 2; s++) begin
        // host set wins over self clear
        if (byte_done && state_r == ST_CTRL && side_sel_r == s[0]) begin
          sw_cfg_r[s] <= ctrl_apply(sw_cfg_r[s], shift_nxt);
        end else if (coef_done[s]) begin
          sw_cfg_r[s].coefficient_reset <= 1'b0;
        end
        if (byte_done && state_r == ST_ITS && side_sel_r == s[0]) begin
          sw_cfg_r[s].input_slot_number <= shift_nxt[`SLOT_MSB:0];
        end
        if (byte_done && state_r == ST_OTS && side_sel_r == s[0]) begin
          sw_cfg_r[s].output_slot_number <= shift_nxt[`SLOT_MSB:0];
        end
      end
    end
  end

  // ****************************************
  // Effective settings
  // ****************************************
  // strap mode slots, coding and law pins, idle pins
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (int s = 0; s < 2; s++) begin
        eff_cfg_r[s] <= '{`IDLE_RST, `FIELD_RST, `FIELD_RST, `FIELD_RST, `FIELD_RST, `SLOT_ZERO, `SLOT_ZERO};
      end
    end else if (strap_act) begin
      eff_cfg_r[`SIDE_X_IDX] <= '{cs_n_s, 1'b0, 1'b0, addr_s[2], addr_s[0], `SLOT_ZERO, `SLOT_ZERO};
      eff_cfg_r[`SIDE_Y_IDX] <= '{sdi_s, 1'b0, 1'b0, addr_s[5], addr_s[3], `SLOT_ZERO, `SLOT_ZERO};
    end else begin
      for (int s = 0; s < 2; s++) begin
        eff_cfg_r[s] <= sw_cfg_r[s];
      end
    end
  end

  // ****************************************
  // Standby and wake
  // ****************************************
  logic both_idle;
  logic standby_r;
  logic asleep_r;
  logic run_r;
  logic [31:0] wake_cnt_r;

  assign both_idle = eff_cfg_r[0].idle_power_down & eff_cfg_r[1].idle_power_down;

  // standby, timed wake, wake only by reset
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      standby_r <= 1'b0;
      asleep_r <= 1'b0;
      run_r <= 1'b0;
      wake_cnt_r <= 32'h0000_0000;
    end else begin
      standby_r <= both_idle;
      wake_cnt_r <= 32'h0000_0000;
      if (both_idle) begin
        asleep_r <= 1'b1;
        run_r <= 1'b0;
      end else if (!asleep_r) begin
        run_r <= 1'b1;
      end else if (REVISED_ALGO) begin
        if (wake_cnt_r == 32'(WAKE_CYCLES - 1)) begin
          asleep_r <= 1'b0;
          run_r <= 1'b1;
        end else begin
          wake_cnt_r <= wake_cnt_r + 32'h0000_0001;
        end
      end
    end
  end

  // ****************************************
  // Slot counters and output drive
  // ****************************************
  logic [1:0] in_act;
  logic [1:0] out_act;
  logic busy_r;
  logic [1:0] in_slot_r;
  logic [1:0] drive_en_r;

  for (genvar s = 0; s < 2; s++) begin : g_side
    slot_counter u_slot (
      .core_clk_in(core_clk_in),
      .reset_n_in(reset_n_in),
      .data_clock_in(dclk_s[s]),
      .frame_sync_in(fs_s[s]),
      .coding_direction_in(eff_cfg_r[s].coding_direction),
      .input_slot_number_in(eff_cfg_r[s].input_slot_number),
      .output_slot_number_in(eff_cfg_r[s].output_slot_number),
      .in_active_out(in_act[s]),
      .out_active_out(out_act[s])
    );
  end

  // tri-state during update, idle tri-states, passthrough uses same slots
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      busy_r <= 1'b0;
      in_slot_r <= 2'b00;
      drive_en_r <= 2'b00;
    end else begin
      busy_r <= (state_r == ST_CTRL) || (state_r == ST_ITS) || (state_r == ST_OTS) || (state_r == ST_DONE);
      for (int s = 0; s < 2; s++) begin
        in_slot_r[s] <= in_act[s] && !eff_cfg_r[s].idle_power_down;
        drive_en_r[s] <= out_act[s] && !eff_cfg_r[s].idle_power_down && !busy_r && run_r;
      end
    end
  end

  assign side_x_cfg_out = eff_cfg_r[`SIDE_X_IDX];
  assign side_y_cfg_out = eff_cfg_r[`SIDE_Y_IDX];
  assign standby_out = standby_r;
  assign engine_run_out = run_r;
  assign update_busy_out = busy_r;
  assign side_x_in_slot_out = in_slot_r[`SIDE_X_IDX];
  assign side_y_in_slot_out = in_slot_r[`SIDE_Y_IDX];
  assign side_x_drive_en_out = drive_en_r[`SIDE_X_IDX];
  assign side_y_drive_en_out = drive_en_r[`SIDE_Y_IDX];

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);

  AST_RESET_IDLE: assert property (
    $rose(reset_n_in) |-> eff_cfg_r[0].idle_power_down && eff_cfg_r[1].idle_power_down && !run_r)
    else $error("reset did not leave both sides idle");
  AST_HW_SLOTS: assert property (
    strap_act |=> (eff_cfg_r[1].input_slot_number == 6'h00) && (eff_cfg_r[0].output_slot_number == 6'h00))
    else $error("strap mode slot not zero");
  AST_HW_CODING: assert property (
    strap_act |=> (eff_cfg_r[1].coding_direction == $past(addr_s[0])) && (eff_cfg_r[0].mu_law == $past(addr_s[5])))
    else $error("strap mode coding or law wrong");
  AST_HW_IDLE: assert property (
    strap_act |=> (eff_cfg_r[1].idle_power_down == $past(cs_n_s)) && (eff_cfg_r[0].idle_power_down == $past(sdi_s)))
    else $error("strap mode idle wrong");
  AST_STANDBY: assert property (
    both_idle |=> standby_r && !run_r)
    else $error("standby not entered");
  AST_OLD_WAKE: assert property (
    (!REVISED_ALGO && asleep_r && !both_idle) |=> !run_r)
    else $error("older variant woke without reset");
  AST_MISMATCH: assert property (
    (state_r == ST_ADDR && byte_done && sw_mode_s && !cs_n_s && !addr_match(shift_nxt, addr_s)) |=> state_r == ST_IGNORE)
    else $error("mismatched write not ignored");
  AST_SIDE_SEL: assert property (
    (state_r == ST_ADDR && state_nxt == ST_CTRL) |=> side_sel_r == $past(shift_r[7]))
    else $error("side select taken from wrong bit");
  AST_COEF_CLEAR: assert property (
    $rose(sw_cfg_r[0].coefficient_reset) |-> ##[1:COEF_MAX] !sw_cfg_r[0].coefficient_reset)
    else $error("coefficient reset not cleared");
  AST_COEF_CLEAR_X: assert property (
    $rose(sw_cfg_r[1].coefficient_reset) |-> ##[1:COEF_MAX] !sw_cfg_r[1].coefficient_reset)
    else $error("side X coefficient reset not cleared");
  AST_BUSY_TRI: assert property (
    busy_r |=> (drive_en_r == 2'b00))
    else $error("output driven during update");

  COV_CTRL_X: cover property (state_r == ST_CTRL && byte_done && side_sel_r);
  COV_IGNORE: cover property (state_r == ST_ADDR ##1 state_r == ST_IGNORE);
  COV_FOUR_BYTES: cover property (state_r == ST_OTS ##1 state_r == ST_DONE);
  COV_WAKE: cover property (asleep_r && !both_idle ##1 run_r);

endmodule

//--- core/pin_sync.sv
// Two-flop synchroniser for a vector of asynchronous pins
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 14
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  // Pins and synchronised copy
  input wire logic [WIDTH-1:0] pins_in,
  output logic [WIDTH-1:0] pins_out
);

  logic [WIDTH-1:0] meta_r;

  if (WIDTH < 1) begin : g_bad_width
    $error("pin_sync needs at least one bit");
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta_r <= '0;
      pins_out <= '0;
    end else begin
      meta_r <= pins_in;
      pins_out <= meta_r;
    end
  end

endmodule

//--- core/slot_counter.sv
// Per-side timeslot counter driven by the sampled data clock and frame sync
`timescale 1ns/1ps
`include "adpcm_cfg_map.svh"
module slot_counter (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  // Synchronised PCM timing
  input wire logic data_clock_in,
  input wire logic frame_sync_in,
  // Settings
  input wire logic coding_direction_in,
  input wire logic [5:0] input_slot_number_in,
  input wire logic [5:0] output_slot_number_in,
  // Slot windows
  output logic in_active_out,
  output logic out_active_out
);

  logic dclk_d_r;
  logic fs_prev_r;
  logic run_r;
  logic [2:0] bit_r;
  logic [5:0] slot_r;
  logic dclk_rise;
  logic start;
  logic [2:0] last_bit;

  assign dclk_rise = data_clock_in & ~dclk_d_r;
  assign start = dclk_rise & frame_sync_in & ~fs_prev_r;
  assign last_bit = coding_direction_in ? `BYTE_LAST_BIT : `NIBBLE_LAST_BIT;

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dclk_d_r <= 1'b0;
      fs_prev_r <= 1'b0;
    end else begin
      dclk_d_r <= data_clock_in;
      if (dclk_rise) begin
        fs_prev_r <= frame_sync_in;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      run_r <= 1'b0;
      bit_r <= 3'h0;
      slot_r <= 6'h00;
    end else if (start) begin
      run_r <= 1'b1;
      bit_r <= 3'h0;
      slot_r <= 6'h00;
    end else if (dclk_rise && run_r) begin
      if (bit_r >= last_bit) begin
        bit_r <= 3'h0;
        if (slot_r == 6'h3F) begin
          run_r <= 1'b0;
        end else begin
          slot_r <= slot_r + 6'h01;
        end
      end else begin
        bit_r <= bit_r + 3'h1;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      in_active_out <= 1'b0;
      out_active_out <= 1'b0;
    end else begin
      in_active_out <= run_r && (slot_r == input_slot_number_in);
      out_active_out <= run_r && (slot_r == output_slot_number_in);
    end
  end

  AST_SLOT_START: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    start |=> (slot_r == 6'h00) && (bit_r == 3'h0) && run_r)
    else $error("slot count did not restart at frame sync");

endmodule

//--- sim/host_model.sv
// Host controller model driving the three-wire configuration port
`timescale 1ns/1ps
module host_model (
  // Serial port pins
  output logic sclk_out,
  output logic sdi_out,
  output logic cs_n_out
);
  // ****
  // Idle levels
  // ****
  initial begin
    sclk_out = 1'b0;
    sdi_out = 1'b0;
    cs_n_out = 1'b1;
  end
  task automatic xfer(input logic [31:0] d, input int n);
    #20;
    cs_n_out = 1'b0;
    #62.5;
    for (int b = 0; b < n * 8; b++) begin
      sdi_out = d[b];
      #62.5;
      sclk_out = 1'b1;
      #62.5;
      sclk_out = 1'b0;
    end
    cs_n_out = 1'b1;
    // Released data line shows the inverse of its last bit
    sdi_out = ~sdi_out;
  endtask
  // clock stays low in strap mode
  task automatic hold(input logic d, input logic c);
    sdi_out = d;
    cs_n_out = c;
  endtask
endmodule

//--- sim/testbench.sv
// Self-checking bench for the channel configuration port
`timescale 1ns/1ps
module testbench;
  import adpcm_cfg_pkg::*;
  typedef struct {logic side; side_cfg_s v;} note_s;
  localparam logic [5:0] ADDR = 6'h2D;
  logic core_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic strap = 1'b1;
  logic [5:0] pins = ADDR;
  logic sclk, config_serial_input, cs_n, standby, run, busy;
  logic [1:0] drv;
  side_cfg_s cfg_x, cfg_y;
  int fails = 0;
  int checks = 0;
  int cycles = 0;
  logic [31:0] seed = 32'hC1F6;
  logic [31:0] r;
  logic [7:0] c;
  note_s n;
  note_s notes[$];
  event look;
  always #5 core_clk_in = ~core_clk_in;
  host_model host (.sclk_out(sclk), .sdi_out(config_serial_input), .cs_n_out(cs_n));
  adpcm_channel_config_port #(.WAKE_CYCLES(50)) uut (
    .core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
    .port_mode_strap_in(strap), .device_address_straps_in(pins),
    .serial_clock_in(sclk), .config_serial_input_in(config_serial_input), .chip_select_n_in(cs_n),
    .side_x_data_clock_in(1'b0), .side_x_frame_sync_in(1'b0),
    .side_y_data_clock_in(1'b0), .side_y_frame_sync_in(1'b0),
    .side_x_cfg_out(cfg_x), .side_y_cfg_out(cfg_y), .standby_out(standby),
    .engine_run_out(run), .update_busy_out(busy), .side_x_in_slot_out(), .side_y_in_slot_out(),
    .side_x_drive_en_out(drv[1]), .side_y_drive_en_out(drv[0])
  );
  // ****
  // Helpers
  // ****
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic note(input logic s, input logic [7:0] k, input logic [5:0] i, input logic [5:0] o);
    notes.push_back('{s, side_cfg_s'({k[5], k[4], k[3], k[2], k[0], i, o})});
    -> look;
  endtask
  task automatic wr(input logic s, input logic [5:0] a, input logic [7:0] k, input logic [5:0] i,
                    input logic [5:0] o, input int nb);
    host.xfer({2'b00, o, 2'b00, i, k, 1'b0, s, a}, nb);
    repeat (6) @(negedge core_clk_in);
  endtask
  task automatic report_and_stop();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ****
  // Monitor and timeout
  // ****
  always @(look) begin
    while (notes.size() > 0) begin
      n = notes.pop_front();
      check(n.side ? "side_x_cfg" : "side_y_cfg", n.side ? cfg_x : cfg_y, n.v);
    end
  end
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      report_and_stop();
    end
  end
  // ****
  // Scenarios
  // ****
  initial begin
    repeat (8) @(negedge core_clk_in);
    reset_n_in = 1'b1;
    repeat (6) @(negedge core_clk_in);
    note(1'b1, 8'h20, 6'h00, 6'h00);
    note(1'b0, 8'h20, 6'h00, 6'h00);
    check("standby", 17'(standby), 17'h1);
    $display("test reset done");
    wr(1'b1, ADDR, 8'h30, 6'h00, 6'h00, 2);
    note(1'b1, 8'h30, 6'h00, 6'h00);
    repeat (40) @(negedge core_clk_in);
    note(1'b1, 8'h20, 6'h00, 6'h00);
    wr(1'b1, ADDR ^ 6'h01, 8'h00, 6'h00, 6'h00, 4);
    note(1'b1, 8'h20, 6'h00, 6'h00);
    $display("test coefficient and mismatch done");
    for (int k = 0; k < 4; k++) begin
      r = rnd();
      c = r[7:0] & 8'h0D;
      wr(k[0], ADDR, c, r[13:8], r[21:16], 4);
      note(k[0], c, r[13:8], r[21:16]);
    end
    repeat (80) @(negedge core_clk_in);
    check("run", 17'(run), 17'h1);
    check("standby", 17'(standby), 17'h0);
    wr(1'b1, ADDR, 8'h20, 6'h00, 6'h00, 2);
    wr(1'b0, ADDR, 8'h20, 6'h00, 6'h00, 2);
    check("standby", 17'(standby), 17'h1);
    check("run", 17'(run), 17'h0);
    check("busy", 17'(busy), 17'h0);
    check("drive_en", 17'(drv), 17'h0);
    $display("test software writes done");
    strap = 1'b0;
    for (int k = 0; k < 3; k++) begin
      r = rnd();
      // address pins 1 and 4 low
      pins = r[5:0] & 6'h2D;
      host.hold(r[8], r[9]);
      repeat (10) @(negedge core_clk_in);
      note(1'b1, {2'b00, r[9], 2'b00, r[2], 1'b0, r[0]}, 6'h00, 6'h00);
      note(1'b0, {2'b00, r[8], 2'b00, r[5], 1'b0, r[3]}, 6'h00, 6'h00);
    end
    $display("test strap mode done");
    // reset pulsed when leaving strap mode
    host.hold(1'b0, 1'b1);
    strap = 1'b1;
    pins = ADDR;
    reset_n_in = 1'b0;
    repeat (8) @(negedge core_clk_in);
    reset_n_in = 1'b1;
    repeat (6) @(negedge core_clk_in);
    note(1'b1, 8'h20, 6'h00, 6'h00);
    note(1'b0, 8'h20, 6'h00, 6'h00);
    check("standby", 17'(standby), 17'h1);
    check("run", 17'(run), 17'h0);
    $display("test mode change reset done");
    report_and_stop();
  end
endmodule
